// ===== verilog/irq_defs.svh
// shared constants for the interrupt request interface
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH
`define IRQ_VOFS_W 16
`define IRQ_VOFS_RST 16'h0000
`define IRQ_AVEC_RST 1'b0
`define IRQ_ASSERTED 1'b0
`define IRQ_NEGATED 1'b1
`define IRQ_ACK_DELAY 2'h1
`define IRQ_FETCH_CYCLES 3'h3
`endif

// ===== verilog/irq_pkg.sv
// types of the interrupt request interface; the vector offset type is shared by both ends, the source type is used by the core end
package irq_pkg;
	typedef logic [15:0] irq_vofs_t;
	typedef enum logic [1:0] {
		IRQ_SRC_NONE = 2'h0,
		IRQ_SRC_EXT = 2'h1,
		IRQ_SRC_CRIT = 2'h2
	} irq_src_e;
endpackage

// ===== verilog/irq_if.sv
// interface joining interrupt controller and core
`timescale 1ns/1ps
interface irq_if;
	logic extReqN;
	logic critReqN;
	logic nmiReqN;
	logic autoVecN;
	irq_pkg::irq_vofs_t vecOffset;
	logic intPending;
	logic intAck;
	modport core (
		input extReqN,
		input critReqN,
		input nmiReqN,
		input autoVecN,
		input vecOffset,
		output intPending,
		output intAck
	);
	modport ctrl (
		output extReqN,
		output critReqN,
		output nmiReqN,
		output autoVecN,
		output vecOffset,
		input intPending,
		input intAck
	);
endinterface

// ===== verilog/irq_core_end.sv
// core end: pending, sampling, commit and acknowledge of interrupts
// Function
// RULE1 - controller holds vector valid while requesting
// RULE2 - pending is combinational from requests and flag
// RULE3 - autovector negated selects supplied vector offset
// RULE4 - request may be sampled in first cycle
// RULE5 - acknowledge marks committed sampled values
// RULE6 - controller changes vector with request lines
// RULE7 - later request waits for handler decode
// RULE8 - commit only values of acknowledged cycle
// RULE9 - blocked external yields to critical request
// RULE10 - inputs active low, sampled on rising edge
// RULE11 - acknowledge is one-cycle pulse per commit
`timescale 1ns/1ps
`include "irq_defs.svh"
module irq_core_end (
	input wire logic clock,
	input wire logic reset,
	irq_if.core bus,
	input wire logic nonmaskableSyndromeFlag,
	input wire logic coreStall,
	input wire logic handlerDecoded,
	output logic commitValid,
	output irq_pkg::irq_src_e commitSrc,
	output irq_pkg::irq_vofs_t commitOffset,
	output logic commitAutoVec,
	output logic handlerBusy
);
	typedef enum logic [1:0] {
		IRQ_ST_IDLE = 2'h0,
		IRQ_ST_SAMPLED = 2'h1,
		IRQ_ST_FETCH = 2'h2
	} irq_core_st_e;

	irq_core_st_e state_r;
	logic ackPulse_r;
	logic extReq;
	logic critReq;
	logic nmiReq;
	logic autoVecSel;
	logic anyReq;
	logic commitNow;
	logic [1:0] srcHeld;
	irq_pkg::irq_src_e liveSrc;

	// RULE10 active low decode, one per pin
	irq_lo_decode #(
		.WIDTH(1)
	) irq_lo_decode_ext_inst (
		.levelN(bus.extReqN),
		.active(extReq)
	);

	irq_lo_decode #(
		.WIDTH(1)
	) irq_lo_decode_crit_inst (
		.levelN(bus.critReqN),
		.active(critReq)
	);

	irq_lo_decode #(
		.WIDTH(1)
	) irq_lo_decode_nmi_inst (
		.levelN(bus.nmiReqN),
		.active(nmiReq)
	);

	irq_lo_decode #(
		.WIDTH(1)
	) irq_lo_decode_avec_inst (
		.levelN(bus.autoVecN),
		.active(autoVecSel)
	);

	assign anyReq = extReq | critReq;

	// RULE2 pending purely combinational, no flop in the path
	assign bus.intPending = extReq
		| critReq
		| nmiReq
		| nonmaskableSyndromeFlag;

	// RULE9 critical outranks external
	always_comb begin
		if (critReq) begin
			liveSrc = irq_pkg::IRQ_SRC_CRIT;
		end else if (extReq) begin
			liveSrc = irq_pkg::IRQ_SRC_EXT;
		end else begin
			liveSrc = irq_pkg::IRQ_SRC_NONE;
		end
	end

	// RULE11 single-cycle acknowledge
	assign bus.intAck = ackPulse_r;
	assign commitValid = ackPulse_r;
	assign handlerBusy = (state_r == IRQ_ST_FETCH);

	// RULE5 commit needs a live request and no stall
	assign commitNow = (state_r == IRQ_ST_SAMPLED)
		&& anyReq
		&& !coreStall;

	// sequence: sample, commit with ack, then hold off until decode
	always_ff @(posedge clock) begin
		if (reset) begin
			state_r <= IRQ_ST_IDLE;
		end else begin
			unique case (state_r)
				IRQ_ST_IDLE: begin
					// RULE4 sample in first asserted cycle
					if (anyReq) begin
						state_r <= IRQ_ST_SAMPLED;
					end
				end
				IRQ_ST_SAMPLED: begin
					// RULE9 stalled commit resamples inputs
					if (!anyReq) begin
						state_r <= IRQ_ST_IDLE;
					end else if (!coreStall) begin
						state_r <= IRQ_ST_FETCH;
					end
				end
				IRQ_ST_FETCH: begin
					// RULE7 next only after decode
					if (handlerDecoded) begin
						state_r <= IRQ_ST_IDLE;
					end
				end
				default: begin
					state_r <= IRQ_ST_IDLE;
				end
			endcase
		end
	end

	// RULE11 pulse lasts one cycle
	always_ff @(posedge clock) begin
		if (reset) begin
			ackPulse_r <= 1'b0;
		end else begin
			ackPulse_r <= commitNow;
		end
	end

	// RULE8 source of the committed cycle only
	irq_hold_reg #(
		.WIDTH(2)
	) irq_hold_reg_src_inst (
		.clock(clock),
		.reset(reset),
		.load(commitNow),
		.resetValue(irq_pkg::IRQ_SRC_NONE),
		.d(liveSrc),
		.q(srcHeld)
	);
	assign commitSrc = irq_pkg::irq_src_e'(srcHeld);

	// RULE5 offset latched with the commit
	irq_hold_reg #(
		.WIDTH(`IRQ_VOFS_W)
	) irq_hold_reg_ofs_inst (
		.clock(clock),
		.reset(reset),
		.load(commitNow),
		.resetValue(`IRQ_VOFS_RST),
		.d(bus.vecOffset),
		.q(commitOffset)
	);

	// RULE3 negated select means vectored
	irq_hold_reg #(
		.WIDTH(1)
	) irq_hold_reg_avec_inst (
		.clock(clock),
		.reset(reset),
		.load(commitNow),
		.resetValue(`IRQ_AVEC_RST),
		.d(autoVecSel),
		.q(commitAutoVec)
	);
endmodule

// active-low pin level to active-high request
module irq_lo_decode #(
	parameter int WIDTH = 1
) (
	input wire logic [WIDTH-1:0] levelN,
	output logic [WIDTH-1:0] active
);
	assign active = ~levelN;
endmodule

// load-enabled hold; keeps committed values until the next commit
module irq_hold_reg #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic load,
	input wire logic [WIDTH-1:0] resetValue,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	always_ff @(posedge clock) begin
		if (reset) begin
			q <= resetValue;
		end else if (load) begin
			q <= d;
		end
	end
endmodule

// ===== verilog/irq_ctrl_end.sv
// controller end: drives requests with matching vector and autovector
`timescale 1ns/1ps
`include "irq_defs.svh"
module irq_ctrl_end (
	input wire logic clock,
	input wire logic reset,
	irq_if.ctrl bus,
	input wire logic extRaise,
	input wire logic critRaise,
	input wire logic nmiRaise,
	input wire irq_pkg::irq_vofs_t extOffset,
	input wire irq_pkg::irq_vofs_t critOffset,
	input wire logic extAutoVec,
	input wire logic critAutoVec,
	output logic pendingSeen,
	output logic ackSeen
);
	logic extReq_r;
	logic critReq_r;
	logic nmiReq_r;
	logic critPrev_r;
	irq_pkg::irq_vofs_t vofs_r;
	logic avecN_r;
	// request levels; an acknowledge retires the highest one served
	always_ff @(posedge clock) begin
		if (reset) begin
			extReq_r <= 1'b0;
			critReq_r <= 1'b0;
			nmiReq_r <= 1'b0;
			critPrev_r <= 1'b0;
		end else begin
			// ack names the commit cycle, so retire by what stood then
			extReq_r <= extRaise | (extReq_r & ~(bus.intAck & ~critPrev_r));
			critReq_r <= critRaise | (critReq_r & ~(bus.intAck & critPrev_r));
			nmiReq_r <= nmiRaise;
			critPrev_r <= critReq_r;
		end
	end
	// RULE6 vector follows the next request set
	always_ff @(posedge clock) begin
		if (reset) begin
			vofs_r <= `IRQ_VOFS_RST;
			avecN_r <= `IRQ_NEGATED;
		end else if (critRaise | (critReq_r & ~(bus.intAck & critPrev_r))) begin
			// RULE1 valid for highest priority
			vofs_r <= critOffset;
			// RULE3 negated selects supplied offset
			avecN_r <= critAutoVec ? `IRQ_ASSERTED : `IRQ_NEGATED;
		end else begin
			vofs_r <= extOffset;
			avecN_r <= extAutoVec ? `IRQ_ASSERTED : `IRQ_NEGATED;
		end
	end
	assign bus.extReqN = extReq_r ? `IRQ_ASSERTED : `IRQ_NEGATED;
	assign bus.critReqN = critReq_r ? `IRQ_ASSERTED : `IRQ_NEGATED;
	assign bus.nmiReqN = nmiReq_r ? `IRQ_ASSERTED : `IRQ_NEGATED;
	assign bus.vecOffset = vofs_r;
	assign bus.autoVecN = avecN_r;
	// RULE8 tolerate delayed acknowledge
	assign pendingSeen = bus.intPending;
	assign ackSeen = bus.intAck;
endmodule

// ===== test/irq_asserts.sv
// checks on the interrupt request wires
`timescale 1ns/1ps
module irq_asserts (
	input wire logic clock,
	input wire logic reset,
	input wire logic extReqN,
	input wire logic critReqN,
	input wire logic nmiReqN,
	input wire logic intPending,
	input wire logic intAck
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	wire req = !extReqN || !critReqN;
	property p_pd; (req || !nmiReqN) |-> intPending; endproperty
	a_pd: assert property (p_pd) else $error("pd");
	property p_pu; intAck |=> !intAck; endproperty
	a_pu: assert property (p_pu) else $error("pu");
	property p_ca; intAck |-> $past(req); endproperty
	a_ca: assert property (p_ca) else $error("ca");
	property p_he; intAck |-> $past(req, 2); endproperty
	a_he: assert property (p_he) else $error("he");
	property p_ga; intAck |=> !intAck [*2]; endproperty
	a_ga: assert property (p_ga) else $error("ga");
	property p_cr; intAck && $past(!critReqN) |=> critReqN; endproperty
	a_cr: assert property (p_cr) else $error("cr");
	property p_ex; intAck && $past(critReqN) |=> extReqN; endproperty
	a_ex: assert property (p_ex) else $error("ex");
	property p_id; !req ##1 !req |=> !intAck; endproperty
	a_id: assert property (p_id) else $error("id");
	c_a: cover property (intAck);
	c_c: cover property (intAck && !critReqN);
	c_e: cover property (intAck && !extReqN);
endmodule

// ===== test/tb.sv
// interrupt interface bench
`timescale 1ns/1ps
`define CK(n, e, s) begin compares++; if ((s) !== (e)) begin errors++; \
	$display("CHECK FAILED %s %h %h", n, e, s); end end
module tb;
	logic clock = 0, reset = 1, fl = 0, st = 0, dc = 0, eR = 0, cR = 0, cv, av;
	logic nR = 0, hb, ps, ak;
	irq_pkg::irq_vofs_t eO = 16'h00A0, cO = 16'h00B0, ofs;
	irq_pkg::irq_src_e src;
	int errors = 0, compares = 0;
	irq_if bus ();
	irq_core_end irq_core_end_inst (.clock, .reset, .bus(bus.core), .handlerBusy(hb),
		.nonmaskableSyndromeFlag(fl), .coreStall(st), .handlerDecoded(dc), .commitValid(cv),
		.commitSrc(src), .commitOffset(ofs), .commitAutoVec(av));
	irq_ctrl_end irq_ctrl_end_inst (.clock, .reset, .bus(bus.ctrl), .extRaise(eR),
		.critRaise(cR), .nmiRaise(nR), .extOffset(eO), .critOffset(cO), .extAutoVec(1'b0),
		.critAutoVec(1'b1), .pendingSeen(ps), .ackSeen(ak));
	irq_asserts chk (.clock, .reset, .extReqN(bus.extReqN), .critReqN(bus.critReqN),
		.nmiReqN(bus.nmiReqN),
		.intPending(bus.intPending), .intAck(bus.intAck));
	task tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task take(input irq_pkg::irq_src_e s, input irq_pkg::irq_vofs_t o, input logic a);
		for (int i = 0; i < 20 && cv !== 1'b1; i++)
			tick(1);
		`CK("src", s, src)
		`CK("ofs", o, ofs)
		`CK("av", a, av)
		`CK("ackSeen", 1'b1, ak)
		tick(2);
		`CK("ack", 1'b0, cv)
		`CK("busy", 1'b1, hb)
		dc = 1;
		tick(1);
		dc = 0;
	endtask
	task close_out;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial forever #50 clock = ~clock;
	initial begin
		repeat (300) @(posedge clock);
		errors++;
		close_out();
	end
	initial begin
		tick(3);
		reset = 0;
		fl = 1;
		#1 `CK("pend", 1'b1, bus.intPending)
		`CK("pendSeen", 1'b1, ps)
		fl = 0;
		nR = 1;
		tick(1);
		`CK("nmiPend", 1'b1, bus.intPending)
		nR = 0;
		st = 1;
		eR = 1;
		tick(1);
		eR = 0;
		tick(4);
		cR = 1;
		tick(1);
		cR = 0;
		`CK("ack", 1'b0, cv)
		`CK("vofs", 16'h00B0, bus.vecOffset)
		`CK("avecN", 1'b0, bus.autoVecN)
		st = 0;
		take(irq_pkg::IRQ_SRC_CRIT, 16'h00B0, 1'b1);
		take(irq_pkg::IRQ_SRC_EXT, 16'h00A0, 1'b0);
		close_out();
	end
endmodule
